// ### src/ivmap_consts.vh
// ivmap_consts.vh: offsets, register map and field positions of the vector map
// assumes: included by bare name from the ivmap design files
`ifndef IVMAP_CONSTS_VH
`define IVMAP_CONSTS_VH

// ----------------------------------------------------------------------------
// vector geometry
// ----------------------------------------------------------------------------
`define IVMAP_VEC_W          15
`define IVMAP_OFS_PORTT      15'h012c
`define IVMAP_OFS_PERIODIC   15'h0100
`define IVMAP_OFS_TCH0       15'h00ac
`define IVMAP_OFS_TCH7       15'h0090
`define IVMAP_OFS_TCH_STEP   15'h0004
`define IVMAP_OFS_ACC_OVF    15'h0088
`define IVMAP_OFS_ACC_EDGE   15'h0084
`define IVMAP_OFS_MOTOR_OVF  15'h0078
`define IVMAP_OFS_SOUND_RDY  15'h0060
`define IVMAP_NSRC           14

// ----------------------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------------------
`define IVMAP_REG_CTRL       8'h00
`define IVMAP_REG_STATUS     8'h04
`define IVMAP_REG_MASK       8'h08
`define IVMAP_REG_PENDING    8'h0c
`define IVMAP_REG_VECTOR     8'h10
`define IVMAP_CTRL_RST       15'h7f00
`define IVMAP_MASK_RST       14'h0000

// ----------------------------------------------------------------------------
// status, mask and pending bit positions
// ----------------------------------------------------------------------------
`define IVMAP_BIT_PORTT      0
`define IVMAP_BIT_PERIODIC   1
`define IVMAP_BIT_TCH0       2
`define IVMAP_BIT_ACC_OVF    10
`define IVMAP_BIT_ACC_EDGE   11
`define IVMAP_BIT_MOTOR_OVF  12
`define IVMAP_BIT_SOUND_RDY  13

`endif

// ### src/ivmap_gate.v
// ivmap_gate.v: per-source gating and wake classification
// assumes: request and enable inputs are on clk_i, no synchroniser needed
`timescale 1ns/100ps
`include "ivmap_consts.vh"

module ivmap_gate (
    // raw requests and local enables
    input  wire [7:0]  portt_pin_irq_i,
    input  wire [7:0]  portt_pin_irq_enables_i,
    input  wire        autonomous_periodic_irq_i,
    input  wire        periodic_irq_enable_i,
    input  wire [7:0]  second_timer_channel_irq_i,
    input  wire [7:0]  second_timer_channel_irq_enables_i,
    input  wire        accumulator_overflow_irq_i,
    input  wire        accumulator_overflow_irq_enable_i,
    input  wire        accumulator_edge_irq_i,
    input  wire        accumulator_edge_irq_enable_i,
    input  wire        motor_timer_overflow_irq_i,
    input  wire        motor_timer_overflow_irq_enable_i,
    input  wire        ready_next_data_irq_i,
    input  wire        ready_next_data_irq_enable_i,
    // gated sources and wake classes
    output wire [13:0] src_o,
    output wire [13:0] stop_wake_o
);
    // bit 0 port t, 1 periodic, 2..9 timer channels, 10 acc ovf, 11 edge,
    // 12 motor, 13 sound
    assign src_o[0]    = |(portt_pin_irq_i & portt_pin_irq_enables_i);
    assign src_o[1]    = autonomous_periodic_irq_i & periodic_irq_enable_i;
    assign src_o[9:2]  = second_timer_channel_irq_i & second_timer_channel_irq_enables_i;
    assign src_o[10]   = accumulator_overflow_irq_i & accumulator_overflow_irq_enable_i;
    assign src_o[11]   = accumulator_edge_irq_i & accumulator_edge_irq_enable_i;
    assign src_o[12]   = motor_timer_overflow_irq_i & motor_timer_overflow_irq_enable_i;
    assign src_o[13]   = ready_next_data_irq_i & ready_next_data_irq_enable_i;
    // only port t and the periodic source reach a stopped core
    assign stop_wake_o = {12'h000, src_o[1:0]};
endmodule // ivmap_gate

// ### src/ivmap_prio.v
// ivmap_prio.v: picks the highest-offset pending source and gives its vector offset
// assumes: pending vector is on clk_i
`timescale 1ns/100ps
`include "ivmap_consts.vh"

module ivmap_prio (
    // pending sources
    input  wire [13:0] pend_i,
    // chosen offset
    output reg         any_o,
    output reg  [14:0] ofs_o
);
    function [14:0] src_ofs;
        input [3:0] idx;
        begin
            case (idx)
                4'h0:    src_ofs = `IVMAP_OFS_PORTT;
                4'h1:    src_ofs = `IVMAP_OFS_PERIODIC;
                4'ha:    src_ofs = `IVMAP_OFS_ACC_OVF;
                4'hb:    src_ofs = `IVMAP_OFS_ACC_EDGE;
                4'hc:    src_ofs = `IVMAP_OFS_MOTOR_OVF;
                4'hd:    src_ofs = `IVMAP_OFS_SOUND_RDY;
                // channel n sits 4 bytes below channel n-1
                default: src_ofs = `IVMAP_OFS_TCH0 - {9'h000, idx - 4'h2, 2'b00};
            endcase
        end
    endfunction

    integer i;
    // lower index has higher offset, so scan downward and let low index win
    always @* begin
        any_o = 1'b0;
        ofs_o = 15'h0000;
        for (i = 13; i >= 0; i = i - 1) begin
            if (pend_i[i]) begin
                any_o = 1'b1;
                ofs_o = src_ofs(i[3:0]);
            end
        end
    end
endmodule // ivmap_prio

// ### src/ivmap_top.v
// ivmap_top.v: interrupt vector map with axi4-lite status, mask and base regs
// assumes: single clk_i domain, synchronous active-high srst_i, requests are
// synchronous level signals from peripherals on the same clock
//
// Chosen here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/100ps
`include "ivmap_consts.vh"

module ivmap_top (
    // clock and reset
    input  wire        clk_i,
    input  wire        srst_i,
    // peripheral requests and local enables
    input  wire [7:0]  portt_pin_irq_i,
    input  wire [7:0]  portt_pin_irq_enables_i,
    input  wire        autonomous_periodic_irq_i,
    input  wire        periodic_irq_enable_i,
    input  wire [7:0]  second_timer_channel_irq_i,
    input  wire [7:0]  second_timer_channel_irq_enables_i,
    input  wire        accumulator_overflow_irq_i,
    input  wire        accumulator_overflow_irq_enable_i,
    input  wire        accumulator_edge_irq_i,
    input  wire        accumulator_edge_irq_enable_i,
    input  wire        motor_timer_overflow_irq_i,
    input  wire        motor_timer_overflow_irq_enable_i,
    input  wire        ready_next_data_irq_i,
    input  wire        ready_next_data_irq_enable_i,
    // core side
    input  wire        core_irq_mask_i,
    output wire        core_irq_req_o,
    output reg  [14:0] core_vector_o,
    output wire        wake_stop_o,
    output wire        wake_wait_o,
    // axi4-lite slave
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // status interrupt
    output wire        irq_o
);
    localparam [1:0] RESP_OKAY   = 2'b00;
    localparam [1:0] RESP_SLVERR = 2'b10;

    wire [13:0] src;
    wire [13:0] stop_src;
    wire        any;
    wire [14:0] ofs;
    wire [13:0] pend;

    reg  [14:0] vec_base_ff;
    reg  [13:0] sts_ff;
    reg  [13:0] nxt_sts;
    reg  [13:0] msk_ff;
    reg  [13:0] src_d_ff;
    reg         aw_hold_ff;
    reg  [7:0]  aw_addr_ff;
    reg         w_hold_ff;
    reg  [31:0] w_data_ff;
    reg  [3:0]  w_strb_ff;

    // ------------------------------------------------------------------------
    // source gating and priority
    // ------------------------------------------------------------------------
    ivmap_gate u_gate (
        .portt_pin_irq_i                    (portt_pin_irq_i),
        .portt_pin_irq_enables_i            (portt_pin_irq_enables_i),
        .autonomous_periodic_irq_i          (autonomous_periodic_irq_i),
        .periodic_irq_enable_i              (periodic_irq_enable_i),
        .second_timer_channel_irq_i         (second_timer_channel_irq_i),
        .second_timer_channel_irq_enables_i (second_timer_channel_irq_enables_i),
        .accumulator_overflow_irq_i         (accumulator_overflow_irq_i),
        .accumulator_overflow_irq_enable_i  (accumulator_overflow_irq_enable_i),
        .accumulator_edge_irq_i             (accumulator_edge_irq_i),
        .accumulator_edge_irq_enable_i      (accumulator_edge_irq_enable_i),
        .motor_timer_overflow_irq_i         (motor_timer_overflow_irq_i),
        .motor_timer_overflow_irq_enable_i  (motor_timer_overflow_irq_enable_i),
        .ready_next_data_irq_i              (ready_next_data_irq_i),
        .ready_next_data_irq_enable_i       (ready_next_data_irq_enable_i),
        .src_o                              (src),
        .stop_wake_o                        (stop_src)
    );

    // global mask blocks delivery but not wake, as a masked source still wakes
    assign pend = core_irq_mask_i ? 14'h0000 : src;

    ivmap_prio u_prio (
        .pend_i (pend),
        .any_o  (any),
        .ofs_o  (ofs)
    );

    assign core_irq_req_o = any;
    assign wake_stop_o    = |stop_src;
    assign wake_wait_o    = |src;

    // ------------------------------------------------------------------------
    // vector register
    // ------------------------------------------------------------------------
    always @(posedge clk_i) begin
        if (srst_i) begin
            core_vector_o <= 15'h0000;
        end else if (any) begin
            core_vector_o <= vec_base_ff + ofs;
        end
    end

    // ------------------------------------------------------------------------
    // sticky status: rising edge of each gated source sets its bit
    // ------------------------------------------------------------------------
    always @* begin
        nxt_sts = sts_ff;
        if (aw_hold_ff && w_hold_ff && !s_axi_bvalid &&
            aw_addr_ff == `IVMAP_REG_STATUS && w_strb_ff[0]) begin
            nxt_sts = nxt_sts & ~{6'h00, w_data_ff[7:0]};
        end
        if (aw_hold_ff && w_hold_ff && !s_axi_bvalid &&
            aw_addr_ff == `IVMAP_REG_STATUS && w_strb_ff[1]) begin
            nxt_sts = nxt_sts & ~{w_data_ff[13:8], 8'h00};
        end
        // set wins over a clear in the same cycle
        nxt_sts = nxt_sts | (src & ~src_d_ff);
    end

    always @(posedge clk_i) begin
        if (srst_i) begin
            sts_ff   <= 14'h0000;
            src_d_ff <= 14'h0000;
        end else begin
            sts_ff   <= nxt_sts;
            src_d_ff <= src;
        end
    end

    assign irq_o = |(sts_ff & msk_ff);

    // ------------------------------------------------------------------------
    // axi4-lite write path: address and data latched independently
    // ------------------------------------------------------------------------
    assign s_axi_awready = !aw_hold_ff;
    assign s_axi_wready  = !w_hold_ff;

    wire wr_go = aw_hold_ff && w_hold_ff && !s_axi_bvalid;
    wire wr_ok = (aw_addr_ff == `IVMAP_REG_CTRL) ||
                 (aw_addr_ff == `IVMAP_REG_STATUS) ||
                 (aw_addr_ff == `IVMAP_REG_MASK);

    always @(posedge clk_i) begin
        if (srst_i) begin
            aw_hold_ff   <= 1'b0;
            aw_addr_ff   <= 8'h00;
            w_hold_ff    <= 1'b0;
            w_data_ff    <= 32'h0000_0000;
            w_strb_ff    <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
            vec_base_ff  <= `IVMAP_CTRL_RST;
            msk_ff       <= `IVMAP_MASK_RST;
        end else begin
            if (s_axi_awvalid && !aw_hold_ff) begin
                aw_hold_ff <= 1'b1;
                aw_addr_ff <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && !w_hold_ff) begin
                w_hold_ff <= 1'b1;
                w_data_ff <= s_axi_wdata;
                w_strb_ff <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_hold_ff   <= 1'b0;
                w_hold_ff    <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
                if (aw_addr_ff == `IVMAP_REG_CTRL) begin
                    if (w_strb_ff[0]) vec_base_ff[7:0]  <= w_data_ff[7:0];
                    if (w_strb_ff[1]) vec_base_ff[14:8] <= w_data_ff[14:8];
                end
                if (aw_addr_ff == `IVMAP_REG_MASK) begin
                    if (w_strb_ff[0]) msk_ff[7:0]  <= w_data_ff[7:0];
                    if (w_strb_ff[1]) msk_ff[13:8] <= w_data_ff[13:8];
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // axi4-lite read path
    // ------------------------------------------------------------------------
    assign s_axi_arready = !s_axi_rvalid;

    always @(posedge clk_i) begin
        if (srst_i) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            case ({s_axi_araddr[7:2], 2'b00})
                `IVMAP_REG_CTRL:    s_axi_rdata <= {17'h00000, vec_base_ff};
                `IVMAP_REG_STATUS:  s_axi_rdata <= {18'h00000, sts_ff};
                `IVMAP_REG_MASK:    s_axi_rdata <= {18'h00000, msk_ff};
                `IVMAP_REG_PENDING: s_axi_rdata <= {18'h00000, src};
                `IVMAP_REG_VECTOR:  s_axi_rdata <= {15'h0000, any, 1'b0, core_vector_o};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // ivmap_top

// ### testbench/ivmap_checker.sv
// ivmap_checker.sv: port assertions for ivmap_top
// assumes: bound onto ivmap_top by name, one clock, srst_i high active
`timescale 1ns/100ps
module ivmap_checker (
    input logic        clk_i, srst_i, core_irq_mask_i,
    input logic [7:0]  portt_pin_irq_i, portt_pin_irq_enables_i,
    input logic [7:0]  second_timer_channel_irq_i, second_timer_channel_irq_enables_i,
    input logic        autonomous_periodic_irq_i, periodic_irq_enable_i,
    input logic        accumulator_overflow_irq_i, accumulator_overflow_irq_enable_i,
    input logic        accumulator_edge_irq_i, accumulator_edge_irq_enable_i,
    input logic        motor_timer_overflow_irq_i, motor_timer_overflow_irq_enable_i,
    input logic        ready_next_data_irq_i, ready_next_data_irq_enable_i,
    input logic        core_irq_req_o, wake_stop_o, wake_wait_o, irq_o,
    input logic [14:0] core_vector_o,
    input logic        s_axi_arvalid, s_axi_rvalid, s_axi_rready, s_axi_bvalid, s_axi_bready
);
    // gated sources in status bit order
    wire [13:0] g = {ready_next_data_irq_i & ready_next_data_irq_enable_i,
                     motor_timer_overflow_irq_i & motor_timer_overflow_irq_enable_i,
                     accumulator_edge_irq_i & accumulator_edge_irq_enable_i,
                     accumulator_overflow_irq_i & accumulator_overflow_irq_enable_i,
                     second_timer_channel_irq_i & second_timer_channel_irq_enables_i,
                     autonomous_periodic_irq_i & periodic_irq_enable_i,
                     |(portt_pin_irq_i & portt_pin_irq_enables_i)};
    wire        any_g = |g;
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);

    chk_req_gated: assert property (core_irq_req_o == (any_g && !core_irq_mask_i))
        else $error("core request disagrees with gated sources");
    chk_stop_wake: assert property (wake_stop_o == (g[0] | g[1]))
        else $error("stop wake wrong");
    chk_wait_wake: assert property (wake_wait_o == any_g)
        else $error("wait wake wrong");
    chk_idle_quiet: assert property (!any_g |-> !core_irq_req_o && !wake_stop_o)
        else $error("request without any source");
    chk_vec_cause: assert property ($changed(core_vector_o) |-> $past(any_g))
        else $error("vector moved without request");
    chk_mask_wake: assert property (core_irq_mask_i && any_g |-> wake_wait_o)
        else $error("global mask blocked wake");
    chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    chk_rresp_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read response dropped early");
    chk_read_cause: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid))
        else $error("read answer without request");

    cover property (core_irq_req_o && wake_stop_o);
    cover property (core_irq_mask_i && any_g);
    cover property (irq_o);
endmodule // ivmap_checker

// ### testbench/ivmap_core_model.sv
// ivmap_core_model.sv: behavioural core, sets its global mask, fetches vectors
// assumes: same clock and reset as ivmap_top
`timescale 1ns/100ps
module ivmap_core_model (
    // clock and reset
    input  logic        clk_i,
    input  logic        srst_i,
    // bench control and block side
    input  logic        mask_req_i,
    input  logic        irq_req_i,
    input  logic [14:0] vector_i,
    output logic        irq_mask_o,
    output logic [14:0] fetched_o
);
    logic seen_ff;
    // fetch one edge late: the vector register trails the request
    always @(posedge clk_i) begin
        if (srst_i) begin
            irq_mask_o <= 1'b0;
            seen_ff    <= 1'b0;
            fetched_o  <= 15'h0000;
        end else begin
            irq_mask_o <= mask_req_i;
            seen_ff    <= irq_req_i;
            if (seen_ff) fetched_o <= vector_i;
        end
    end
endmodule // ivmap_core_model

// ### testbench/tb_interrupt_vector_map.sv
// tb_interrupt_vector_map.sv: self-checking bench for ivmap_top
// assumes: design under src/, checker and core model compiled first
`timescale 1ns/100ps
module tb_interrupt_vector_map;
    logic        clk_i = 1'b0, srst_i = 1'b1, mask_req = 1'b0;
    logic [13:0] req_v = 14'h0000, en_v = 14'h0000;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_o;
    wire [1:0]   s_axi_bresp, s_axi_rresp;
    wire [31:0]  s_axi_rdata;
    wire         core_irq_mask_i, core_irq_req_o, wake_stop_o, wake_wait_o;
    wire [14:0]  core_vector_o, fetched;
    // only pin 7 enabled: the other pins request too and must stay gated
    wire [7:0] portt_pin_irq_i = {8{req_v[0]}}, portt_pin_irq_enables_i = {en_v[0], 7'h00};
    wire autonomous_periodic_irq_i = req_v[1], periodic_irq_enable_i = en_v[1];
    wire [7:0] second_timer_channel_irq_i = req_v[9:2];
    wire [7:0] second_timer_channel_irq_enables_i = en_v[9:2];
    wire accumulator_overflow_irq_i = req_v[10], accumulator_overflow_irq_enable_i = en_v[10];
    wire accumulator_edge_irq_i = req_v[11], accumulator_edge_irq_enable_i = en_v[11];
    wire motor_timer_overflow_irq_i = req_v[12], motor_timer_overflow_irq_enable_i = en_v[12];
    wire ready_next_data_irq_i = req_v[13], ready_next_data_irq_enable_i = en_v[13];
    int n_fail = 0, total_checks = 0;

    ivmap_top i_dut (.*);
    ivmap_core_model i_core (.clk_i(clk_i), .srst_i(srst_i), .mask_req_i(mask_req),
        .irq_req_i(core_irq_req_o), .vector_i(core_vector_o),
        .irq_mask_o(core_irq_mask_i), .fetched_o(fetched));

    always #5 clk_i = ~clk_i;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic cmp(input string what, input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge clk_i);
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (n > 50) begin n_fail++; stop_test; end
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        int n;
        @(posedge clk_i);
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (n > 50) begin n_fail++; stop_test; end
        end while (!s_axi_rvalid);
        cmp(what, s_axi_rdata, exp);
        cmp("read resp", {30'h0, s_axi_rresp}, (a > 8'h10) ? 32'h2 : 32'h0);
        s_axi_rready <= 1'b0;
    endtask
    function automatic logic [14:0] ofs(input int k);
        case (k)
            0: ofs = 15'h012c;
            1: ofs = 15'h0100;
            10: ofs = 15'h0088;
            11: ofs = 15'h0084;
            12: ofs = 15'h0078;
            13: ofs = 15'h0060;
            default: ofs = 15'h00ac - 15'(4 * (k - 2));
        endcase
    endfunction

    // ------------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------------
    initial begin
        logic [1:0] r;
        repeat (20) @(posedge clk_i);
        srst_i <= 1'b0;
        rd_chk("base reset", 8'h00, 32'h7f00);
        rd_chk("mask reset", 8'h08, 32'h0);
        rd_chk("unmapped read", 8'h40, 32'h0);
        axi_wr(8'h40, 32'h1, r);
        cmp("unmapped write", {30'h0, r}, 32'h2);
        for (int k = 0; k < 14; k++) begin
            @(posedge clk_i);
            req_v <= 14'h1 << k;
            en_v <= 14'h1 << k;
            @(posedge clk_i);
            #1;
            cmp("request", {31'h0, core_irq_req_o}, 32'h1);
            cmp("wake stop", {31'h0, wake_stop_o}, {31'h0, k < 2});
            cmp("wake wait", {31'h0, wake_wait_o}, 32'h1);
            cmp("vector", {17'h0, core_vector_o}, {17'h0, 15'h7f00 + ofs(k)});
            @(posedge clk_i);
            en_v <= 14'h0;
            @(posedge clk_i);
            #1;
            cmp("disabled request", {31'h0, core_irq_req_o}, 32'h0);
            cmp("disabled wake", {31'h0, wake_wait_o}, 32'h0);
        end
        rd_chk("status", 8'h04, 32'h3fff);
        axi_wr(8'h08, 32'h2000, r);
        cmp("mask write resp", {30'h0, r}, 32'h0);
        #1;
        cmp("irq set", {31'h0, irq_o}, 32'h1);
        axi_wr(8'h04, 32'h2000, r);
        #1;
        cmp("irq cleared", {31'h0, irq_o}, 32'h0);
        rd_chk("status cleared", 8'h04, 32'h1fff);
        // base near the top so the sum wraps at 15 bits
        axi_wr(8'h00, 32'h7fe0, r);
        @(posedge clk_i);
        req_v <= 14'h2001;
        en_v <= 14'h2001;
        repeat (3) @(posedge clk_i);
        #1;
        cmp("fetched vector", {17'h0, fetched}, 32'h010c);
        @(posedge clk_i);
        mask_req <= 1'b1;
        repeat (2) @(posedge clk_i);
        #1;
        cmp("masked request", {31'h0, core_irq_req_o}, 32'h0);
        cmp("masked wake", {31'h0, wake_stop_o}, 32'h1);
        cmp("masked wait wake", {31'h0, wake_wait_o}, 32'h1);
        rd_chk("pending", 8'h0c, 32'h2001);
        rd_chk("vector reg", 8'h10, 32'h010c);
        stop_test;
    end
endmodule // tb_interrupt_vector_map

bind ivmap_top ivmap_checker u_chk (.*);
